/* tamper_supervisor_reset.sv */
// What this block does
// RL1 - Reset output low while supply is under reset level or manual reset low.
// RL2 - After power-up supply rise, reset held low a full time-out, then released.
// RL3 - Every reset assertion lasts at least one complete time-out period.
// RL4 - Time-out timer clears on supply drop, restarts when supply returns.
// RL5 - Reset held while manual input low, plus one time-out after release.
// RL6 - Manual input bounce yields one continuous reset assertion.
// RL7 - Switch to battery only when supply below both switchover level and battery.
// RL8 - Return from battery to main supply uses hysteresis.
// RL9 - Battery removal with valid supply causes no reset.
// RL10 - Backup mode fixes power-fail, manual reset, reset, indicators and pull-up source.
// RL11 - Power-fail output low while sense input below its own threshold.
// RL12 - Below switchover level power-fail compare off, output held low.
// RL13 - When main power returns, power-fail output follows sense input again.
// RL14 - Supply dips shorter than 40 us do not produce a reset.
// RL15 - Four tamper inputs; any one off its normal level drives alarm low.
// RL16 - Alarm does not latch; it returns high when no fault remains.
// RL17 - Inputs a and c normally high; tamper flagged when low.
// RL18 - Inputs b and d normally low; tamper flagged when high.
// RL19 - Each tamper input is glitch filtered.
// RL20 - Alarm asserted while selected supply is over or under its trip levels.
// RL21 - Alarm low in every variant; protected output on, floated or grounded.
// RL22 - Alarms disabled until first supply rise and time-out expiry.
// RL23 - Switch indicator low on main supply, high on battery.
// RL24 - Float and ground variants force switch indicator high during alarm.
// RL25 - Time-out and filter lengths are parameters; levels enter as comparator bits.
// RL26 - Output variant is a static input sampled at reset release.
`timescale 1ns/1ps
`default_nettype none

module tamper_supervisor_reset
    import tsr_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = tsr_pkg::TSR_TIMEOUT_CYC, // RL25
    parameter int unsigned BOUNCE_CYC = tsr_pkg::TSR_BOUNCE_CYC,
    parameter int unsigned DIP_CYC = tsr_pkg::TSR_DIP_CYC,
    parameter int unsigned GLITCH_CYC = tsr_pkg::TSR_GLITCH_CYC
) (
    input wire logic i_clock,                     // 125 MHz time base
    input wire logic i_resetn,                    // Async reset, active low
    input wire tsr_pkg::tsr_levels_s i_levels,    // Comparator decisions, async
    input wire logic i_manual_reset_in_n,         // Manual reset pin, active low
    input wire logic i_tamper_in_a,               // Normally high tamper pin
    input wire logic i_tamper_in_b,               // Normally low tamper pin
    input wire logic i_tamper_in_c,               // Normally high tamper pin
    input wire logic i_tamper_in_d,               // Normally low tamper pin
    input wire tsr_pkg::tsr_variant_e i_variant,  // Static output variant
    output logic o_reset_n,                       // System reset, active low
    output logic o_powerfail_flag_out_n,          // Power-fail flag, active low
    output logic o_security_alarm_out_n,          // Security alarm, active low
    output logic o_supply_switch,                 // High when fed from battery
    output logic o_battery_low_flag_n,            // Battery low, released in backup
    output logic o_tamper_pullup_from_battery,    // Pull-up supply from battery
    output tsr_pkg::tsr_protected_supply_out_s o_protected_supply_out, // Protected output drive
    output logic o_armed                          // Alarms enabled
);

    // ------------------------------------------------------------
    // Synchronizers
    // ------------------------------------------------------------
    localparam int unsigned SYNC_W = 7 + 1 + TSR_NUM_TAMPER;

    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;
    tsr_levels_s lv;
    logic mr_n_sync;
    logic [TSR_NUM_TAMPER-1:0] tamper_sync;

    // Manual reset travels inverted so the cleared synchroniser reads as released
    assign raw_in = {i_levels, !i_manual_reset_in_n, i_tamper_in_d, i_tamper_in_c,
                     i_tamper_in_b, i_tamper_in_a};

    tsr_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_async(raw_in),
        .o_sync(sync_in)
    );

    assign lv = tsr_levels_s'(sync_in[SYNC_W-1 -: 7]); // RL25
    assign mr_n_sync = !sync_in[TSR_NUM_TAMPER];
    assign tamper_sync = sync_in[TSR_NUM_TAMPER-1:0];

    // ------------------------------------------------------------
    // Supply dip filter and manual reset debounce
    // ------------------------------------------------------------
    logic supply_ok;
    logic mr_n_clean;

    tsr_filter #(
        .CYCLES(DIP_CYC),
        .INIT(1'b0)
    ) u_dip (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_level(lv.above_reset),
        .o_level(supply_ok)
    ); // RL14

    // Filter only the release so a press acts at once
    logic [TSR_CNT_W-1:0] mr_cnt_ff;
    logic [TSR_CNT_W-1:0] nxt_mr_cnt;
    logic mr_n_ff;
    logic nxt_mr_n;
    logic mr_done;

    assign mr_done = (mr_cnt_ff >= TSR_CNT_W'(BOUNCE_CYC - 1));
    assign nxt_mr_cnt = (!mr_n_sync || mr_n_ff || mr_done) ? '0 : mr_cnt_ff + 1'b1; // RL6
    assign nxt_mr_n = !mr_n_sync ? 1'b0 : (mr_done ? 1'b1 : mr_n_ff); // RL6

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            mr_cnt_ff <= '0;
            mr_n_ff <= 1'b1;
        end else begin
            mr_cnt_ff <= nxt_mr_cnt;
            mr_n_ff <= nxt_mr_n;
        end
    end

    assign mr_n_clean = mr_n_ff;

    // ------------------------------------------------------------
    // Supply selection
    // ------------------------------------------------------------
    tsr_supply_e supply_ff;
    tsr_supply_e nxt_supply;
    logic to_battery;
    logic to_main;
    logic on_battery;

    assign to_battery = !lv.above_switchover && !lv.above_battery; // RL7
    assign to_main = lv.above_return; // RL8

    always_comb begin
        nxt_supply = supply_ff;
        unique case (supply_ff)
            TSR_SUP_MAIN: begin
                if (to_battery) begin
                    nxt_supply = TSR_SUP_BATTERY; // RL7
                end
            end
            TSR_SUP_BATTERY: begin
                if (to_main) begin
                    nxt_supply = TSR_SUP_MAIN; // RL8
                end
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            supply_ff <= TSR_SUP_MAIN;
        end else begin
            supply_ff <= nxt_supply;
        end
    end

    assign on_battery = (supply_ff == TSR_SUP_BATTERY);

    // ------------------------------------------------------------
    // Reset time-out
    // ------------------------------------------------------------
    logic [TSR_CNT_W-1:0] rst_cnt_ff;
    logic [TSR_CNT_W-1:0] nxt_rst_cnt;
    logic rst_n_ff;
    logic nxt_rst_n;
    logic rst_cause;
    logic rst_expired;

    // Manual reset ignored in backup; being on battery is itself a reset cause
    assign rst_cause = !supply_ok || on_battery || (!mr_n_clean && !on_battery); // RL1 RL9 RL10
    assign rst_expired = (rst_cnt_ff >= TSR_CNT_W'(TIMEOUT_CYC - 1));
    assign nxt_rst_cnt = rst_cause ? '0 : (rst_expired ? rst_cnt_ff : rst_cnt_ff + 1'b1); // RL4 RL5
    assign nxt_rst_n = rst_cause ? 1'b0 : (rst_expired ? 1'b1 : rst_n_ff); // RL2 RL3 RL5

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_cnt_ff <= '0;
            rst_n_ff <= TSR_RST_N;
        end else begin
            rst_cnt_ff <= nxt_rst_cnt;
            rst_n_ff <= nxt_rst_n;
        end
    end

    // ------------------------------------------------------------
    // Alarm arming and variant capture
    // ------------------------------------------------------------
    logic armed_ff;
    logic nxt_armed;
    logic var_taken_ff;
    tsr_variant_e variant_ff;
    tsr_variant_e nxt_variant;

    assign nxt_armed = armed_ff || (rst_n_ff && supply_ok); // RL22
    assign nxt_variant = var_taken_ff ? variant_ff : i_variant; // RL26

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            armed_ff <= 1'b0;
            var_taken_ff <= 1'b0;
            variant_ff <= TSR_VAR_ALWAYS_ON;
        end else begin
            armed_ff <= nxt_armed;
            var_taken_ff <= 1'b1;
            variant_ff <= nxt_variant;
        end
    end

    // ------------------------------------------------------------
    // Tamper filtering and alarm
    // ------------------------------------------------------------
    logic [TSR_NUM_TAMPER-1:0] tamper_clean;
    logic [TSR_NUM_TAMPER-1:0] tamper_hit;

    genvar gi;
    generate
        for (gi = 0; gi < TSR_NUM_TAMPER; gi++) begin : g_tamper
            tsr_filter #(
                .CYCLES(GLITCH_CYC),
                .INIT(TSR_TAMPER_NORMAL[gi])
            ) u_glitch (
                .i_clock(i_clock),
                .i_resetn(i_resetn),
                .i_level(tamper_sync[gi]),
                .o_level(tamper_clean[gi])
            ); // RL19
            assign tamper_hit[gi] = (tamper_clean[gi] != TSR_TAMPER_NORMAL[gi]); // RL15 RL17 RL18
        end
    endgenerate

    logic fault;
    logic alarm_ff;
    logic nxt_alarm;

    assign fault = (|tamper_hit) || lv.overvoltage || lv.undervoltage; // RL15 RL20
    assign nxt_alarm = armed_ff && fault; // RL16 RL22

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            alarm_ff <= 1'b0;
        end else begin
            alarm_ff <= nxt_alarm;
        end
    end

    // ------------------------------------------------------------
    // Power-fail and indicator outputs
    // ------------------------------------------------------------
    logic pfo_n_ff;
    logic nxt_pfo_n;
    logic sw_ff;
    logic nxt_sw;
    logic force_sw;
    tsr_protected_supply_out_s protected_supply_out_ff;
    tsr_protected_supply_out_s nxt_protected_supply_out;

    assign nxt_pfo_n = !on_battery && lv.above_switchover && lv.powerfail_ok; // RL11 RL12 RL13
    assign force_sw = alarm_ff && (variant_ff != TSR_VAR_ALWAYS_ON); // RL24
    assign nxt_sw = on_battery || force_sw; // RL23 RL24
    assign nxt_protected_supply_out.drive_on = !(alarm_ff && (variant_ff != TSR_VAR_ALWAYS_ON)); // RL21
    assign nxt_protected_supply_out.drive_high_z = alarm_ff && (variant_ff == TSR_VAR_HIGH_Z); // RL21
    assign nxt_protected_supply_out.drive_ground = alarm_ff && (variant_ff == TSR_VAR_GROUND); // RL21

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pfo_n_ff <= 1'b0;
            sw_ff <= 1'b0;
            protected_supply_out_ff <= '{drive_on: 1'b1, drive_high_z: 1'b0, drive_ground: 1'b0};
        end else begin
            pfo_n_ff <= nxt_pfo_n;
            sw_ff <= nxt_sw;
            protected_supply_out_ff <= nxt_protected_supply_out;
        end
    end

    assign o_reset_n = rst_n_ff;
    assign o_powerfail_flag_out_n = pfo_n_ff;
    assign o_security_alarm_out_n = !alarm_ff; // RL21
    assign o_supply_switch = sw_ff;
    assign o_battery_low_flag_n = 1'b1; // RL10
    assign o_tamper_pullup_from_battery = on_battery; // RL10
    assign o_protected_supply_out = protected_supply_out_ff;
    assign o_armed = armed_ff;

endmodule : tamper_supervisor_reset

`default_nettype wire

/* tsr_pkg.sv */
package tsr_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned TSR_CLK_MHZ = 125;
    localparam int unsigned TSR_TIMEOUT_MS = 200;
    localparam int unsigned TSR_TIMEOUT_CYC = TSR_TIMEOUT_MS * 1000 * TSR_CLK_MHZ;
    localparam int unsigned TSR_DIP_US = 40;
    localparam int unsigned TSR_DIP_CYC = TSR_DIP_US * TSR_CLK_MHZ;
    localparam int unsigned TSR_GLITCH_US = 10;
    localparam int unsigned TSR_GLITCH_CYC = TSR_GLITCH_US * TSR_CLK_MHZ;
    localparam int unsigned TSR_BOUNCE_MS = 10;
    localparam int unsigned TSR_BOUNCE_CYC = TSR_BOUNCE_MS * 1000 * TSR_CLK_MHZ;
    localparam int unsigned TSR_CNT_W = 32;
    localparam int unsigned TSR_NUM_TAMPER = 4;

    // ------------------------------------------------------------
    // Reset values and tamper polarity
    // ------------------------------------------------------------
    localparam logic [3:0] TSR_TAMPER_NORMAL = 4'h5;
    localparam logic TSR_RST_N = 1'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TSR_VAR_ALWAYS_ON,
        TSR_VAR_HIGH_Z,
        TSR_VAR_GROUND
    } tsr_variant_e;

    typedef enum {
        TSR_SUP_MAIN,
        TSR_SUP_BATTERY
    } tsr_supply_e;

    typedef struct packed {
        logic above_reset;
        logic above_switchover;
        logic above_battery;
        logic above_return;
        logic powerfail_ok;
        logic overvoltage;
        logic undervoltage;
    } tsr_levels_s;

    typedef struct packed {
        logic drive_on;
        logic drive_high_z;
        logic drive_ground;
    } tsr_protected_supply_out_s;

endpackage : tsr_pkg

/* tsr_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module tsr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clock,              // System clock
    input wire logic i_resetn,             // Async reset, active low
    input wire logic [WIDTH-1:0] i_async,  // Asynchronous inputs
    output logic [WIDTH-1:0] o_sync        // Synchronized outputs
);
    import tsr_pkg::*;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule : tsr_sync

`default_nettype wire

/* tsr_filter.sv */
`timescale 1ns/1ps
`default_nettype none

// Output follows the input only after it has been steady for CYCLES cycles
module tsr_filter #(
    parameter int unsigned CYCLES = 4,
    parameter logic INIT = 1'b0
) (
    input wire logic i_clock,   // System clock
    input wire logic i_resetn,  // Async reset, active low
    input wire logic i_level,   // Synchronized level
    output logic o_level        // Filtered level
);
    import tsr_pkg::*;

    logic [TSR_CNT_W-1:0] cnt_ff;
    logic [TSR_CNT_W-1:0] nxt_cnt;
    logic level_ff;
    logic nxt_level;
    logic differs;
    logic settled;

    assign differs = (i_level != level_ff);
    assign settled = (cnt_ff >= TSR_CNT_W'(CYCLES - 1));
    assign nxt_cnt = (differs && !settled) ? cnt_ff + 1'b1 : '0;
    assign nxt_level = (differs && settled) ? i_level : level_ff;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_ff <= '0;
            level_ff <= INIT;
        end else begin
            cnt_ff <= nxt_cnt;
            level_ff <= nxt_level;
        end
    end

    assign o_level = level_ff;

endmodule : tsr_filter

`default_nettype wire

/* tamper_supervisor_reset_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module tsr_chk
    import tsr_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = 50,
    parameter int unsigned DIP_CYC = 4,
    parameter int unsigned GLITCH_CYC = 4
) (
    input wire logic i_clock, // Clock
    input wire logic i_resetn, // Reset
    input wire tsr_pkg::tsr_levels_s i_levels, // Levels
    input wire logic i_manual_reset_in_n, // Button
    input wire logic i_tamper_in_a, // Tamper
    input wire logic i_tamper_in_b, // Tamper
    input wire logic i_tamper_in_c, // Tamper
    input wire logic i_tamper_in_d, // Tamper
    input wire tsr_pkg::tsr_variant_e i_variant, // Variant
    input wire logic o_reset_n, // Reset out
    input wire logic o_powerfail_flag_out_n, // Power-fail
    input wire logic o_security_alarm_out_n, // Alarm
    input wire logic o_supply_switch, // Switch
    input wire logic o_battery_low_flag_n, // Battery low
    input wire logic o_tamper_pullup_from_battery, // Backup
    input wire tsr_pkg::tsr_protected_supply_out_s o_protected_supply_out, // Drive
    input wire logic o_armed // Armed
);
    logic [31:0] low_cnt_ff;
    logic [31:0] nxt_low_cnt;
    logic [31:0] dip_cnt_ff;
    logic [31:0] nxt_dip_cnt;
    logic [31:0] hit_cnt_ff;
    logic [31:0] nxt_hit_cnt;
    logic hit;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    assign hit = !i_tamper_in_a | i_tamper_in_b | !i_tamper_in_c | i_tamper_in_d;
    assign nxt_low_cnt = o_reset_n ? 32'h0 : low_cnt_ff + 32'h1;
    assign nxt_dip_cnt = i_levels.above_reset ? 32'h0 : dip_cnt_ff + 32'h1;
    assign nxt_hit_cnt = (o_armed && hit) ? hit_cnt_ff + 32'h1 : 32'h0;
    // Length of the current reset pulse, supply low spell and tamper spell
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            low_cnt_ff <= 32'h0;
            dip_cnt_ff <= 32'h0;
            hit_cnt_ff <= 32'h0;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
            dip_cnt_ff <= nxt_dip_cnt;
            hit_cnt_ff <= nxt_hit_cnt;
        end
    end
    property p_timeout;
        $rose(o_reset_n) |-> low_cnt_ff >= TIMEOUT_CYC;
    endproperty
    a_timeout: assert property (p_timeout) else $error("reset pulse short");
    property p_supply_low;
        dip_cnt_ff == DIP_CYC + 4 |-> !o_reset_n;
    endproperty
    a_supply_low: assert property (p_supply_low) else $error("no reset");
    property p_manual;
        (!i_manual_reset_in_n)[*3] |-> ##[0:2] !o_reset_n;
    endproperty
    a_manual: assert property (p_manual) else $error("button ignored");
    property p_backup;
        o_tamper_pullup_from_battery[*3] |-> !o_reset_n && !o_powerfail_flag_out_n;
    endproperty
    a_backup: assert property (p_backup) else $error("backup state");
    property p_pf;
        (!i_levels.powerfail_ok || !i_levels.above_switchover)[*4] |-> !o_powerfail_flag_out_n;
    endproperty
    a_pf: assert property (p_pf) else $error("power-fail high");
    property p_switch;
        o_tamper_pullup_from_battery == $past(o_tamper_pullup_from_battery)
            && o_security_alarm_out_n && $past(o_security_alarm_out_n)
            |-> o_supply_switch == o_tamper_pullup_from_battery;
    endproperty
    a_switch: assert property (p_switch) else $error("switch flag");
    property p_drive;
        !o_security_alarm_out_n && !$past(o_security_alarm_out_n) |->
            o_protected_supply_out == {i_variant == TSR_VAR_ALWAYS_ON,
            i_variant == TSR_VAR_HIGH_Z, i_variant == TSR_VAR_GROUND}
            && (o_supply_switch || i_variant == TSR_VAR_ALWAYS_ON);
    endproperty
    a_drive: assert property (p_drive) else $error("alarm drive");
    property p_unarmed;
        !o_armed |-> o_security_alarm_out_n;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("early alarm");
    property p_tamper;
        hit_cnt_ff == GLITCH_CYC + 4 |-> !o_security_alarm_out_n;
    endproperty
    a_tamper: assert property (p_tamper) else $error("tamper missed");
endmodule : tsr_chk
bind tamper_supervisor_reset tsr_chk #(
    .TIMEOUT_CYC(TIMEOUT_CYC), .DIP_CYC(DIP_CYC), .GLITCH_CYC(GLITCH_CYC)
) tsr_chk_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_levels(i_levels),
    .i_manual_reset_in_n(i_manual_reset_in_n), .i_tamper_in_a(i_tamper_in_a),
    .i_tamper_in_b(i_tamper_in_b), .i_tamper_in_c(i_tamper_in_c),
    .i_tamper_in_d(i_tamper_in_d), .i_variant(i_variant), .o_reset_n(o_reset_n),
    .o_powerfail_flag_out_n(o_powerfail_flag_out_n),
    .o_security_alarm_out_n(o_security_alarm_out_n), .o_supply_switch(o_supply_switch),
    .o_battery_low_flag_n(o_battery_low_flag_n),
    .o_tamper_pullup_from_battery(o_tamper_pullup_from_battery),
    .o_protected_supply_out(o_protected_supply_out), .o_armed(o_armed)
);
`default_nettype wire

/* tsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Push-button with contact chatter, host start counter
// ------------------------------------------------------------
module tsr_host_model (
    input wire logic i_clock, // Clock
    input wire logic i_press, // Held
    input wire logic i_reset_n, // Host reset
    output logic o_button_n, // Contact
    output int o_boots // Starts
);
    logic last = 1'h0;
    int chatter = 0;
    initial o_button_n = 1'h1;
    initial o_boots = 0;
    // Contact chatters for six cycles on each press and release
    always @(negedge i_clock) begin
        if (i_press != last) chatter = 6;
        last = i_press;
        if (chatter > 0) begin
            chatter = chatter - 1;
            o_button_n = ~o_button_n;
        end else o_button_n = !i_press;
    end
    always @(posedge i_reset_n) o_boots = o_boots + 1;
endmodule : tsr_host_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsr_pkg::*;
    localparam int TO = 50;
    logic i_clock = 1'h0;
    logic i_resetn = 1'h0;
    logic press = 1'h0;
    logic [3:0] tam = 4'ha;
    tsr_levels_s lv = '0;
    tsr_variant_e var_sel = TSR_VAR_ALWAYS_ON;
    tsr_protected_supply_out_s prot;
    logic rst_n, pf_n, alarm_n, sw, low_n, on_bat, armed, btn_n;
    int boots, b0, c, mismatches = 0, tests_run = 0, seed = 61, bat_m = 0, armed_m = 0;
    always #4 i_clock = ~i_clock;
    tamper_supervisor_reset #(
        .TIMEOUT_CYC(TO), .BOUNCE_CYC(8), .DIP_CYC(4), .GLITCH_CYC(4)
    ) tamper_supervisor_reset_inst (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_levels(lv),
        .i_manual_reset_in_n(btn_n), .i_tamper_in_a(tam[3]), .i_tamper_in_b(tam[2]),
        .i_tamper_in_c(tam[1]), .i_tamper_in_d(tam[0]), .i_variant(var_sel),
        .o_reset_n(rst_n), .o_powerfail_flag_out_n(pf_n), .o_security_alarm_out_n(alarm_n),
        .o_supply_switch(sw), .o_battery_low_flag_n(low_n),
        .o_tamper_pullup_from_battery(on_bat), .o_protected_supply_out(prot), .o_armed(armed)
    );
    tsr_host_model tsr_host_model_inst (
        .i_clock(i_clock), .i_press(press), .i_reset_n(rst_n),
        .o_button_n(btn_n), .o_boots(boots)
    );
    // ------------------------------------------------------------
    // Compare and wait helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit
    task automatic cmp_min(input string nm, input int e, input int g);
        tests_run++;
        if (g < e) begin
            mismatches++;
            $display("[FAIL] %s expected >=%0d seen %0d", nm, e, g);
        end
    endtask : cmp_min
    task automatic ticks(input int k);
        repeat (k) @(negedge i_clock);
    endtask : ticks
    task automatic wait_rel(input int lim);
        c = 0;
        while (rst_n !== 1'h1) begin
            @(negedge i_clock);
            c++;
            if (c > lim) begin
                mismatches++;
                $display("[FAIL] reset release expected by %0d seen none", lim);
                summarize();
            end
        end
    endtask : wait_rel
    // Reference model: backup state with hysteresis, alarm gated by arming
    task automatic look(input logic e_rst);
        logic f;
        ticks(12);
        if (!lv.above_switchover && !lv.above_battery) bat_m = 1;
        else if (lv.above_return) bat_m = 0;
        f = armed_m && (tam != 4'ha || lv.overvoltage || lv.undervoltage);
        cmp_bit("reset", e_rst, rst_n);
        cmp_bit("pf", lv.powerfail_ok && lv.above_switchover && !bat_m, pf_n);
        cmp_bit("alarm", !f, alarm_n);
        cmp_bit("armed", armed_m != 0, armed);
        cmp_bit("switch", bat_m || (f && var_sel != TSR_VAR_ALWAYS_ON), sw);
        cmp_bit("backup", bat_m != 0, on_bat);
        cmp_bit("batlow", 1'h1, low_n);
        cmp_bit("on", !f || var_sel == TSR_VAR_ALWAYS_ON, prot.drive_on);
        cmp_bit("float", f && var_sel == TSR_VAR_HIGH_Z, prot.drive_high_z);
        cmp_bit("ground", f && var_sel == TSR_VAR_GROUND, prot.drive_ground);
    endtask : look
    task automatic boot(input tsr_variant_e v);
        i_resetn = 1'h0;
        var_sel = v;
        lv = 7'h3e;
        bat_m = 0;
        armed_m = 0;
        ticks(5);
        i_resetn = 1'h1;
        look(1'h0);
        lv.overvoltage = 1'h0;
        lv.above_reset = 1'h1;
        wait_rel(200);
        cmp_min("power-up hold", TO, c);
        armed_m = 1;
    endtask : boot
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int v = 0; v < 3; v++) begin
            boot(tsr_variant_e'(v));
            for (int k = 0; k < 4; k++) begin
                tam[k] = ~tam[k];
                ticks(1 + ($unsigned($random(seed)) % 2));
                tam[k] = ~tam[k];
                look(1'h1);
                tam[k] = ~tam[k];
                look(1'h1);
                tam[k] = ~tam[k];
                look(1'h1);
            end
        end
        lv.overvoltage = 1'h1;
        look(1'h1);
        lv.overvoltage = 1'h0;
        lv.undervoltage = 1'h1;
        look(1'h1);
        lv.undervoltage = 1'h0;
        lv.powerfail_ok = 1'h0;
        look(1'h1);
        lv.powerfail_ok = 1'h1;
        lv.above_battery = 1'h0;
        look(1'h1);
        lv.above_battery = 1'h1;
        lv.above_reset = 1'h0;
        ticks(2);
        lv.above_reset = 1'h1;
        look(1'h1);
        lv.above_reset = 1'h0;
        look(1'h0);
        lv.above_reset = 1'h1;
        ticks(30);
        lv.above_reset = 1'h0;
        ticks(10);
        lv.above_reset = 1'h1;
        wait_rel(200);
        cmp_min("restart hold", TO, c);
        b0 = boots;
        press = 1'h1;
        look(1'h0);
        press = 1'h0;
        wait_rel(300);
        cmp_min("button hold", TO, c);
        cmp_bit("one pulse", 1'h1, boots == b0 + 1);
        lv = 7'h14;
        look(1'h0);
        lv.above_battery = 1'h0;
        look(1'h0);
        press = 1'h1;
        look(1'h0);
        press = 1'h0;
        lv.above_switchover = 1'h1;
        lv.above_battery = 1'h1;
        look(1'h0);
        lv.above_return = 1'h1;
        look(1'h0);
        lv.above_reset = 1'h1;
        wait_rel(300);
        look(1'h1);
        summarize();
    end
endmodule : testbench
`default_nettype wire
